// ==== rtl/darx_cs_store.sv ====
`include "darx_defs.svh"
`default_nettype none
// Holds one subframe's channel-status block, loaded on a strobe
module darx_cs_store #(
    parameter int WIDTH = 40
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Load side
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] data_in,
    // Stored block, straight from flip-flops
    output logic      [WIDTH-1:0] data_out
);
    logic [WIDTH-1:0] store_q;        // Stored block
    logic [WIDTH-1:0] store_d;        // Next stored block

    // Load a complete block only, so reads never see a half-updated block
    always_comb begin
        store_d = store_q;
        if (load) begin
            store_d = data_in;
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            store_q <= WIDTH'(`DARX_RST_CS);
        end else begin
            store_q <= store_d;
        end
    end

    assign data_out = store_q;
endmodule // darx_cs_store
`default_nettype wire

// ==== rtl/darx_defs.svh ====
`ifndef DARX_DEFS_SVH
`define DARX_DEFS_SVH
// Register addresses (8-bit register address space)
`define DARX_ADDR_RX_STATUS     8'h59
`define DARX_ADDR_LEFT_CS_LOW   8'h5A
`define DARX_ADDR_LEFT_CS_MID   8'h5B
`define DARX_ADDR_LEFT_CS_HIGH  8'h5C
`define DARX_ADDR_RIGHT_CS_LOW  8'h5D
`define DARX_ADDR_RIGHT_CS_MID  8'h5E
`define DARX_ADDR_RIGHT_CS_HIGH 8'h5F
// Field positions in the receiver status register
`define DARX_BIT_LOCK           0
`define DARX_BIT_BIPHASE_ERR    1
`define DARX_BIT_TX_DISABLED    8
// Reset values
`define DARX_RST_WORD           16'h0000
`define DARX_RST_CS             40'h00_0000_0000
`endif

// ==== rtl/darx_pkg.sv ====
`default_nettype none
package darx_pkg;
    // Register address and data words
    typedef logic [7:0]  darx_addr_t;
    typedef logic [15:0] darx_word_t;
    // One subframe's channel-status block
    typedef logic [39:0] darx_cs_t;
    // Read port states
    typedef enum logic [1:0] {
        DARX_RD_IDLE = 2'b01,
        DARX_RD_DONE = 2'b10
    } darx_rd_state_e;
endpackage
`default_nettype wire

// ==== rtl/darx_status_regs.sv ====
`include "darx_defs.svh"
`default_nettype none
module darx_status_regs #(
    parameter int CS_BITS = 40          // Channel-status bits kept per subframe
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Status levels from the receiver decoder and encoder
    input  wire logic                  tx_output_disabled,
    input  wire logic                  biphase_error,
    input  wire logic                  decoder_locked,
    // Channel-status blocks from the decoder, one strobe per completed block
    input  wire logic                  cs_valid,
    input  wire darx_pkg::darx_cs_t    left_cs,
    input  wire darx_pkg::darx_cs_t    right_cs,
    // Register read port from the control bus slave
    input  wire logic                  rd_req,
    input  wire darx_pkg::darx_addr_t  rd_addr,
    output logic                       rd_valid,
    output darx_pkg::darx_word_t       rd_data,
    output logic                       rd_hit
);
    import darx_pkg::*;

    // Register map, all read-only, 16 bits wide:
    //   0x59  receiver status: bit 8 transmitter disabled, bit 1 biphase error,
    //         bit 0 decoder lock, every other bit zero
    //   0x5A  left channel-status bits 15..0
    //   0x5B  left channel-status bits 31..16
    //   0x5C  left channel-status bits 39..32 in the low byte, upper byte zero
    //   0x5D  right channel-status bits 15..0
    //   0x5E  right channel-status bits 31..16
    //   0x5F  right channel-status bits 39..32 in the low byte, upper byte zero
    // Any other address answers with zero and a cleared rd_hit, so the bus slave
    // can tell a hole in the map from a register that happens to read zero.
    //
    // Read timing: a request sampled on one rising edge is answered on the next,
    // rd_valid standing one cycle per taken request and rd_data/rd_hit holding
    // until the next taken request. Back-to-back requests are served every cycle.
    //
    // Limitation: the port has no wait states and no error response; a hole in
    // the map is reported only through rd_hit.
    //
    // Reset clears the answer stage and both stores, so a read before the first
    // decoded block returns zero rather than stale bits.

    // Channel-status stores
    darx_cs_t       left_q;            // Left subframe channel status
    darx_cs_t       right_q;           // Right subframe channel status

    // Live status and formatted register words
    darx_word_t     status_word;       // Live receiver status word
    darx_word_t     left_low_word;     // Left bits 15..0
    darx_word_t     left_mid_word;     // Left bits 31..16
    darx_word_t     left_high_word;    // Left bits 39..32, upper byte zero
    darx_word_t     right_low_word;    // Right bits 15..0
    darx_word_t     right_mid_word;    // Right bits 31..16
    darx_word_t     right_high_word;   // Right bits 39..32, upper byte zero

    // Address decode results
    darx_word_t     sel_word;          // Word chosen by the address
    logic           sel_hit;           // Address is one of ours

    // Read port registers
    darx_word_t     data_q;            // Read data register
    darx_word_t     data_d;            // Next read data
    logic           hit_q;             // Address hit register
    logic           hit_d;             // Next address hit
    logic           valid_q;           // Answer strobe register
    logic           valid_d;           // Next answer strobe
    darx_rd_state_e state_q;           // Read port state
    darx_rd_state_e state_d;           // Next read port state

    // Both subframes share one strobe so left and right stay from the same block.
    // A read on the loading edge still sees the previous block, never a mix.
    darx_cs_store #(.WIDTH(CS_BITS)) u_left (
        .clk      (clk),
        .rst      (rst),
        .load     (cs_valid),
        .data_in  (left_cs),
        .data_out (left_q)
    );

    darx_cs_store #(.WIDTH(CS_BITS)) u_right (
        .clk      (clk),
        .rst      (rst),
        .load     (cs_valid),
        .data_in  (right_cs),
        .data_out (right_q)
    );

    // Status flags are live levels: they follow the decoder, not sticky.
    // A flag that drops between two reads is simply not seen; that suits
    // lock and error indications that the host polls for their present state.
    always_comb begin
        status_word                        = `DARX_RST_WORD;
        status_word[`DARX_BIT_TX_DISABLED] = tx_output_disabled;
        status_word[`DARX_BIT_BIPHASE_ERR] = biphase_error;
        status_word[`DARX_BIT_LOCK]        = decoder_locked;
    end

    // Slice the stored blocks into register words.
    // Bit i of a block lands on register bit i mod 16, so no reversal is needed.
    always_comb begin
        // Low words: bits 15..0 at matching positions
        left_low_word   = left_q[15:0];
        right_low_word  = right_q[15:0];
        // Middle words: bits 31..16, most significant bit at bit 15
        left_mid_word   = left_q[31:16];
        right_mid_word  = right_q[31:16];
        // High words: bits 39..32 in the low byte, upper byte held at zero
        left_high_word  = {8'h00, left_q[39:32]};
        right_high_word = {8'h00, right_q[39:32]};
    end

    // Address decode; unmapped addresses read zero and drop rd_hit.
    // Kept apart from the read port so the map can grow without touching timing.
    always_comb begin
        sel_word = `DARX_RST_WORD;
        sel_hit  = 1'b1;
        case (rd_addr)
            // Status register
            `DARX_ADDR_RX_STATUS: begin
                sel_word = status_word;
            end
            // Left subframe words
            `DARX_ADDR_LEFT_CS_LOW: begin
                sel_word = left_low_word;
            end
            `DARX_ADDR_LEFT_CS_MID: begin
                sel_word = left_mid_word;
            end
            `DARX_ADDR_LEFT_CS_HIGH: begin
                sel_word = left_high_word;
            end
            // Right subframe words
            `DARX_ADDR_RIGHT_CS_LOW: begin
                sel_word = right_low_word;
            end
            `DARX_ADDR_RIGHT_CS_MID: begin
                sel_word = right_mid_word;
            end
            `DARX_ADDR_RIGHT_CS_HIGH: begin
                sel_word = right_high_word;
            end
            // Holes in the map read zero
            default: begin
                sel_word = `DARX_RST_WORD;
                sel_hit  = 1'b0;
            end
        endcase
    end

    // Read port: a request is answered on the next edge for exactly one cycle.
    // Reading touches only this output stage, so flags and stores are unaffected.
    // The word is captured at the taking edge, so a status change after that
    // edge cannot tear a word that the bus slave is still shifting out.
    always_comb begin
        state_d = state_q;
        data_d  = data_q;
        hit_d   = hit_q;
        valid_d = 1'b0;
        case (state_q)
            // Nothing outstanding
            DARX_RD_IDLE: begin
                if (rd_req) begin
                    data_d  = sel_word;
                    hit_d   = sel_hit;
                    valid_d = 1'b1;
                    state_d = DARX_RD_DONE;
                end
            end
            // Answer standing this cycle
            DARX_RD_DONE: begin
                // Back-to-back requests are served without a gap
                if (rd_req) begin
                    data_d  = sel_word;
                    hit_d   = sel_hit;
                    valid_d = 1'b1;
                    state_d = DARX_RD_DONE;
                end else begin
                    state_d = DARX_RD_IDLE;
                end
            end
            // Illegal code: fall back to idle and raise no answer
            default: begin
                state_d = DARX_RD_IDLE;
            end
        endcase
    end

    // Register stage of the read port
    always_ff @(posedge clk) begin
        if (rst) begin
            // Nothing answered, nothing left over from before the reset
            state_q <= DARX_RD_IDLE;
            valid_q <= 1'b0;
            data_q  <= `DARX_RST_WORD;
            hit_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            valid_q <= valid_d;
            data_q  <= data_d;
            hit_q   <= hit_d;
        end
    end

    // Outputs straight from flip-flops, so the bus slave sees no decode glitches
    assign rd_valid = valid_q;
    assign rd_data  = data_q;
    assign rd_hit   = hit_q;
endmodule // darx_status_regs
`default_nettype wire

// ==== verification/darx_chk_sva.sv ====
`default_nettype none
module darx_chk import darx_pkg::*; (
    // Watched ports of the register block
    input wire logic       clk, rst, tx_output_disabled, biphase_error, decoder_locked,
    input wire logic       cs_valid, rd_req, rd_valid, rd_hit,
    input wire darx_cs_t   left_cs, right_cs,
    input wire darx_addr_t rd_addr,
    input wire darx_word_t rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff rst;
    darx_cs_t l_q, r_q;  // Shadow stores, so a read at a load edge still expects the old block
    always_ff @(posedge clk) begin
        l_q <= rst ? '0 : cs_valid ? left_cs : l_q;
        r_q <= rst ? '0 : cs_valid ? right_cs : r_q;
    end
    // Which side a channel-status read points at, and which word of it
    wire darx_cs_t c  = rd_addr > 8'h5C ? r_q : l_q;
    wire logic     st = rd_req && rd_addr == 8'h59;
    wire logic     hi = rd_req && (rd_addr == 8'h5C || rd_addr == 8'h5F);
    wire logic     md = rd_req && (rd_addr == 8'h5B || rd_addr == 8'h5E);
    wire logic     lo = rd_req && (rd_addr == 8'h5A || rd_addr == 8'h5D);
    read_answer_a: assert property (1'b1 |=> rd_valid == $past(rd_req)) else $error("no answer");
    tx_bit_a: assert property (st |=> rd_data[8] == $past(tx_output_disabled)) else $error("b8");
    err_bit_a: assert property (st |=> rd_data[1] == $past(biphase_error)) else $error("b1");
    lock_bit_a: assert property (st |=> rd_data[0] == $past(decoder_locked)) else $error("b0");
    cs_high_a: assert property (hi |=> rd_data == {8'h00, $past(c[39:32])}) else $error("hi");
    cs_mid_a: assert property (md |=> rd_data == $past(c[31:16])) else $error("mid");
    cs_low_a: assert property (lo |=> rd_data == $past(c[15:0])) else $error("low");
    reserved_zero_a: assert property (st |=> rd_hit && {rd_data[15:9], rd_data[7:2]} == '0)
        else $error("reserved bits set");
endmodule // darx_chk
bind darx_status_regs darx_chk u_darx_chk (
    .clk(clk), .rst(rst), .tx_output_disabled(tx_output_disabled),
    .biphase_error(biphase_error), .decoder_locked(decoder_locked), .cs_valid(cs_valid),
    .rd_req(rd_req), .rd_valid(rd_valid), .rd_hit(rd_hit), .left_cs(left_cs),
    .right_cs(right_cs), .rd_addr(rd_addr), .rd_data(rd_data)
);
`default_nettype wire

// ==== verification/darx_host.sv ====
`default_nettype none
// Control bus host: one read at a time, request held across the taking edge
module darx_host import darx_pkg::*; (
    input  wire logic  clk,
    output darx_addr_t rd_addr,
    output logic       rd_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rd_req = 1'b0;
    initial rd_addr = 8'h00;
    task automatic rd(input darx_addr_t a);
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_req = 1'b0;
        rd_addr = ~a;  // Stale address would hide a decoder that ignores rd_req
    endtask
    // Two reads on consecutive edges: the request never drops in between
    task automatic rd_pair(input darx_addr_t a, input darx_addr_t b);
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_addr = b;
        @(negedge clk);
        rd_req = 1'b0;
        rd_addr = ~b;
    endtask
endmodule // darx_host
`default_nettype wire

// ==== verification/darx_status_regs_tb.sv ====
`default_nettype none
module darx_status_regs_tb import darx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, tx_output_disabled = 0, biphase_error = 0, decoder_locked = 0;
    logic       cs_valid = 0, rd_req, rd_valid, rd_hit;
    darx_cs_t   left_cs = '0, right_cs = '0;
    darx_addr_t rd_addr;
    darx_word_t rd_data;
    int         failures = 0, samples_checked = 0;
    // Rows: address, expected hit, expected word; two unmapped neighbours last
    logic [24:0] rows [9] = '{{8'h59,1'b1,16'h0101}, {8'h5A,1'b1,16'h9E17},
        {8'h5B,1'b1,16'hC3F0}, {8'h5C,1'b1,16'h005A}, {8'h5D,1'b1,16'h8B2D},
        {8'h5E,1'b1,16'h0F1E}, {8'h5F,1'b1,16'h003C}, {8'h58,1'b0,16'h0000},
        {8'h60,1'b0,16'h0000}};
    darx_status_regs u_darx_status_regs (
        .clk(clk), .rst(rst), .tx_output_disabled(tx_output_disabled),
        .biphase_error(biphase_error), .decoder_locked(decoder_locked), .cs_valid(cs_valid),
        .left_cs(left_cs), .right_cs(right_cs), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_hit(rd_hit));
    darx_host u_darx_host (.clk(clk), .rd_req(rd_req), .rd_addr(rd_addr));
    initial forever #20 clk = ~clk;
    task automatic cmp_w(input darx_word_t g, input darx_word_t e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic g, input logic e);
        cmp_w({15'h0000, g}, {15'h0000, e});
    endtask
    // One read, checked in the single cycle that the answer stands
    task automatic chk(input darx_addr_t a, input logic h, input darx_word_t d);
        u_darx_host.rd(a);
        cmp_b(rd_valid, 1'b1);
        cmp_b(rd_hit, h);
        cmp_w(rd_data, d);
    endtask
    task automatic summarize();
        $display("checked=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 0;
        left_cs = 40'h5A_C3F0_9E17;
        right_cs = 40'h3C_0F1E_8B2D;
        cs_valid = 1;
        @(negedge clk) cs_valid = 0;
        tx_output_disabled = 1;
        decoder_locked = 1;
        // Second pass shows reads leave everything as it was
        repeat (2) foreach (rows[i]) chk(rows[i][24:17], rows[i][16], rows[i][15:0]);
        for (int s = 0; s < 8; s++) begin
            {tx_output_disabled, biphase_error, decoder_locked} = s[2:0];
            chk(8'h59, 1'b1, {7'h00, s[2], 6'h00, s[1:0]});
        end
        // Back-to-back reads; the first is taken on the edge that loads new blocks
        fork
            u_darx_host.rd_pair(8'h5B, 8'h5E);
            begin
                @(negedge clk);
                {left_cs, right_cs} = {40'h12_3456_789A, 40'h9A_BCDE_F012};
                cs_valid = 1'b1;
                @(negedge clk);
                cs_valid = 1'b0;
                cmp_b(rd_valid, 1'b1);
                cmp_w(rd_data, 16'hC3F0);
            end
        join
        cmp_b(rd_valid, 1'b1);
        cmp_w(rd_data, 16'hBCDE);
        rst = 1;
        @(negedge clk) rst = 0;
        // Mid-run reset clears the answer stage and the left store that 0x5A reads
        cmp_b(rd_valid, 1'b0);
        cmp_b(rd_hit, 1'b0);
        cmp_w(rd_data, 16'h0000);
        chk(8'h5A, 1'b1, 16'h0000);
        summarize();
    end
    initial begin
        #80000;
        failures++;
        summarize();
    end
endmodule // darx_status_regs_tb
`default_nettype wire
